// *** logic/ups_pkg.sv ***
/*
 Constants for the serial-port power-save controller: register map,
 field layout, reset values, mode codes and timing counts.
 Assumes a 20 MHz module clock.
*/
package ups_pkg;
    // Register byte offsets
    localparam logic [7:0] UPS_OFF_CFG    = 8'h00;
    localparam logic [7:0] UPS_OFF_CTRL   = 8'h04;
    localparam logic [7:0] UPS_OFF_STAT   = 8'h08;
    // Field positions
    localparam int UPS_CFG_MODE_LSB       = 0;
    localparam int UPS_CFG_TMO_LSB        = 16;
    localparam int UPS_CTRL_FC_BIT        = 0;
    localparam int UPS_CTRL_VAR_LSB       = 4;
    localparam int UPS_STAT_EN_BIT        = 0;
    localparam int UPS_STAT_ACT_BIT       = 1;
    localparam int UPS_STAT_DEEP_BIT      = 2;
    localparam int UPS_STAT_REJ_BIT       = 3;
    localparam int UPS_STAT_RXOK_BIT      = 4;
    // Power-save configurations
    localparam logic [2:0] UPS_MODE_OFF   = 3'h0;
    localparam logic [2:0] UPS_MODE_CYC   = 3'h1;
    localparam logic [2:0] UPS_MODE_RTS   = 3'h2;
    localparam logic [2:0] UPS_MODE_DTR   = 3'h3;
    localparam logic [2:0] UPS_MODE_CYC2  = 3'h4;
    localparam logic [2:0] UPS_VAR_MAXONE = 3'h1;
    // Reset values
    localparam logic [2:0]  UPS_RST_MODE  = 3'h0;
    localparam logic [15:0] UPS_RST_TMO   = 16'h07d0;
    // Timing
    localparam int unsigned UPS_CLK_HZ    = 20_000_000;
    localparam int unsigned UPS_WAKE_MS   = 15;
    localparam int unsigned UPS_WIN_MS    = 30;
    localparam int unsigned UPS_OFF_S     = 31;
    localparam int unsigned UPS_FRAME_US  = 5000;
    localparam int unsigned UPS_WAKE_CYC  = UPS_WAKE_MS * (UPS_CLK_HZ / 1000);
    localparam int unsigned UPS_WIN_CYC   = UPS_WIN_MS * (UPS_CLK_HZ / 1000);
    localparam int unsigned UPS_OFF_CYC   = UPS_OFF_S * UPS_CLK_HZ;
    localparam int unsigned UPS_FRAME_CYC = UPS_FRAME_US * (UPS_CLK_HZ / 1_000_000);

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_IDLE,
        ST_WAKE,
        ST_WIN,
        ST_DEEP
    } ups_state_t;
endpackage : ups_pkg

// *** logic/ups_ctrl.sv ***
/*
 Power-save controller for the host serial port: decides port enable,
 CTS, active/idle/deep-sleep state and whether received characters count.
 Assumes rxd, rts_n, dtr_n come straight from pins; the other status
 inputs and character strobes come from logic on clk.
*/
// Added by the designer: the AHB-Lite slave port and the register offsets.
// Notes on behaviour
// - Cyclic modes disable port after inactivity timeout
// - Cyclic modes reopen port periodically, then retime
// - Holds: wake window (cyclic only), pending output, data call (not in DTR mode)
// - Unregistered: 30 ms open, 31 s closed
// - Every character restarts the inactivity timer
// - With flow control, CTS low when enabled
// - Deep sleep keeps the port off
// - RTS mode refused while flow control on
// - RTS mode: RTS off closes port now
// - RTS rising reopens port, active after 15 ms
// - RTS held on: no idle, port open
// - DTR mode refused unless variant 0 or 1
// - DTR mode: DTR off closes port now
// - DTR rising reopens port, active after 15 ms
// - DTR held on: no idle, port open
// - DTR level still offered; CTS shows state
// - Idle receive edge wakes port within 15 ms
// - Wake character and wake-time data discarded
// - Line wake only in cyclic modes
// - Line wake cannot be switched off
// - Timeout counted in frames, default 2000
// - Mode 0: always active, CTS on
module ups_ctrl #(
    parameter int unsigned P_WAKE_CYC  = ups_pkg::UPS_WAKE_CYC,  // Wake-up time
    parameter int unsigned P_WIN_CYC   = ups_pkg::UPS_WIN_CYC,   // Unregistered open window
    parameter int unsigned P_OFF_CYC   = ups_pkg::UPS_OFF_CYC,   // Unregistered closed time
    parameter int unsigned P_FRAME_CYC = ups_pkg::UPS_FRAME_CYC  // One frame period
) (
    input  wire logic        clk,          // 20 MHz clock
    input  wire logic        rst,          // Async reset, high
    input  wire logic        hsel,         // AHB select
    input  wire logic [31:0] haddr,        // AHB address
    input  wire logic [1:0]  htrans,       // AHB transfer type
    input  wire logic        hwrite,       // AHB write
    input  wire logic [2:0]  hsize,        // AHB size, word only
    input  wire logic [31:0] hwdata,       // AHB write data
    input  wire logic        hready,       // AHB bus ready
    output logic      [31:0] hrdata,       // AHB read data
    output logic             hreadyout,    // AHB slave ready
    output logic             hresp,        // AHB response, OKAY
    input  wire logic        rxd,          // Host data pin, idle high
    input  wire logic        rts_n,        // Host RTS pin, low is ON
    input  wire logic        dtr_n,        // Host DTR pin, low is ON
    input  wire logic        rx_char,      // Character received pulse
    input  wire logic        tx_char,      // Character sent pulse
    input  wire logic        tx_pending,   // Device output waiting
    input  wire logic        psd_call,     // External data call active
    input  wire logic        net_wake,     // Network activity window
    input  wire logic        net_reg,      // Registered to a network
    input  wire logic        deep_req,     // Low-power timers allow deep sleep
    output logic             port_en,      // Port enabled
    output logic             cts_n,        // CTS pin, low is ON
    output logic             active_mode,  // Module in active mode
    output logic             rx_accept,    // Received characters valid
    output logic             dtr_on        // Synced DTR level for other use
);
    import ups_pkg::*;

    typedef struct packed {
        logic [2:0]  rxd_sync;
        logic [1:0]  rts_sync;
        logic [1:0]  dtr_sync;
        logic [2:0]  mode;
        logic [15:0] timeout;
        logic        fc_en;
        logic [2:0]  variant;
        logic        reject;
        ups_state_t  state;
        logic [31:0] cnt;
        logic [31:0] div;
        logic [15:0] frames;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        port_en;
        logic        cts_n;
        logic        active;
        logic        rx_accept;
        logic        dtr_on;
    } ups_regs_t;

    ups_regs_t s_ff;
    ups_regs_t nxt_s;

    logic        rts_is_on;
    logic        dtr_is_on;
    logic        rx_fall;
    logic        traffic;
    logic        cyc_mode;
    logic        line_on;
    logic        hold;
    logic        frame_tick;
    logic        addr_ok;
    logic        cfg_bad;
    logic [2:0]  new_mode;
    logic [31:0] rd_val;

    // Second sync stage for RTS and DTR, second and third for rxd; first stage feeds nothing else
    assign rts_is_on = !s_ff.rts_sync[1];
    assign dtr_is_on = !s_ff.dtr_sync[1];
    assign rx_fall   = s_ff.rxd_sync[2] && !s_ff.rxd_sync[1];
    assign traffic   = rx_char || tx_char;
    assign cyc_mode  = (s_ff.mode == UPS_MODE_CYC) || (s_ff.mode == UPS_MODE_CYC2);
    assign line_on   = (s_ff.mode == UPS_MODE_RTS) ? rts_is_on : dtr_is_on;
    assign addr_ok   = hsel && hready && htrans[1];
    assign frame_tick = (s_ff.div == 32'(P_FRAME_CYC - 1));
    assign new_mode  = hwdata[UPS_CFG_MODE_LSB +: 3];

    // Reasons to keep the port open whatever the lines say
    always_comb begin
        if (cyc_mode) begin
            hold = tx_pending || psd_call || net_wake;
        end else if (s_ff.mode == UPS_MODE_RTS) begin
            hold = tx_pending || psd_call;
        end else begin
            hold = tx_pending;
        end
    end

    // Status word shows live block state
    always_comb begin
        rd_val = 32'h0;
        case (haddr[7:0])
            UPS_OFF_CFG: begin
                rd_val[UPS_CFG_MODE_LSB +: 3] = s_ff.mode;
                rd_val[UPS_CFG_TMO_LSB +: 16] = s_ff.timeout;
            end
            UPS_OFF_CTRL: begin
                rd_val[UPS_CTRL_FC_BIT]       = s_ff.fc_en;
                rd_val[UPS_CTRL_VAR_LSB +: 3] = s_ff.variant;
            end
            UPS_OFF_STAT: begin
                rd_val[UPS_STAT_EN_BIT]   = s_ff.port_en;
                rd_val[UPS_STAT_ACT_BIT]  = s_ff.active;
                rd_val[UPS_STAT_DEEP_BIT] = (s_ff.state == ST_DEEP);
                rd_val[UPS_STAT_REJ_BIT]  = s_ff.reject;
                rd_val[UPS_STAT_RXOK_BIT] = s_ff.rx_accept;
            end
            default: rd_val = 32'h0;
        endcase
    end

    // Refused configurations leave the old mode in place; the timeout field is still written
    always_comb begin
        cfg_bad = 1'b0;
        if (new_mode == UPS_MODE_RTS && s_ff.fc_en) begin
            cfg_bad = 1'b1;
        end else if (new_mode == UPS_MODE_DTR && s_ff.variant > UPS_VAR_MAXONE) begin
            cfg_bad = 1'b1;
        end else if (new_mode > UPS_MODE_CYC2) begin
            cfg_bad = 1'b1;
        end
    end

    // Next-state logic
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rxd_sync = {s_ff.rxd_sync[1:0], rxd};
        nxt_s.rts_sync = {s_ff.rts_sync[0], rts_n};
        nxt_s.dtr_sync = {s_ff.dtr_sync[0], dtr_n};
        nxt_s.div = frame_tick ? 32'h0 : s_ff.div + 32'h1;
        nxt_s.cnt = s_ff.cnt + 32'h1;

        // Power state
        if (s_ff.mode == UPS_MODE_OFF) begin
            nxt_s.state = ST_ACTIVE;
        end else if (cyc_mode) begin
            case (s_ff.state)
                ST_ACTIVE: begin
                    if (traffic || hold) begin
                        nxt_s.frames = 16'h0;
                    end else if (s_ff.frames >= s_ff.timeout) begin
                        nxt_s.state = ST_IDLE;
                        nxt_s.cnt   = 32'h0;
                    end else if (frame_tick) begin
                        nxt_s.frames = s_ff.frames + 16'h1;
                    end
                end
                ST_IDLE: begin
                    if (deep_req) begin
                        nxt_s.state = ST_DEEP;
                    end else if (rx_fall) begin
                        nxt_s.state = ST_WAKE;
                        nxt_s.cnt   = 32'h0;
                    end else if (hold) begin
                        nxt_s.state  = ST_ACTIVE;
                        nxt_s.frames = 16'h0;
                    end else if (net_reg) begin
                        nxt_s.cnt = 32'h0;
                    end else if (s_ff.cnt >= 32'(P_OFF_CYC - 1)) begin
                        nxt_s.state = ST_WIN;
                        nxt_s.cnt   = 32'h0;
                    end
                end
                ST_WAKE: begin
                    // Wake character counts as last data
                    if (s_ff.cnt >= 32'(P_WAKE_CYC - 1)) begin
                        nxt_s.state  = ST_ACTIVE;
                        nxt_s.frames = 16'h0;
                    end
                end
                ST_WIN: begin
                    if (traffic || hold) begin
                        nxt_s.state  = ST_ACTIVE;
                        nxt_s.frames = 16'h0;
                    end else if (s_ff.cnt >= 32'(P_WIN_CYC - 1)) begin
                        nxt_s.state = ST_IDLE;
                        nxt_s.cnt   = 32'h0;
                    end
                end
                ST_DEEP: begin
                    if (!deep_req) begin
                        nxt_s.state = ST_IDLE;
                        nxt_s.cnt   = 32'h0;
                    end
                end
                default: nxt_s.state = ST_ACTIVE;
            endcase
        end else begin
            // Line-controlled modes; line level beats deep sleep in idle, but cannot leave deep sleep while deep_req holds
            case (s_ff.state)
                ST_ACTIVE: begin
                    if (!line_on && !hold) begin
                        nxt_s.state = ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (line_on) begin
                        nxt_s.state = ST_WAKE;
                        nxt_s.cnt   = 32'h0;
                    end else if (hold) begin
                        nxt_s.state = ST_ACTIVE;
                    end else if (deep_req) begin
                        nxt_s.state = ST_DEEP;
                    end
                end
                ST_WAKE: begin
                    if (!line_on && !hold) begin
                        nxt_s.state = ST_IDLE;
                    end else if (s_ff.cnt >= 32'(P_WAKE_CYC - 1)) begin
                        nxt_s.state = ST_ACTIVE;
                    end
                end
                ST_DEEP: begin
                    if (!deep_req) begin
                        nxt_s.state = ST_IDLE;
                    end
                end
                default: nxt_s.state = ST_IDLE;
            endcase
        end

        // Bus: capture address phase, act in data phase
        nxt_s.hreadyout = 1'b1;
        nxt_s.wr_pend   = addr_ok && hwrite;
        nxt_s.wr_addr   = haddr[7:0];
        nxt_s.hrdata    = (addr_ok && !hwrite) ? rd_val : 32'h0;
        if (s_ff.wr_pend) begin
            case (s_ff.wr_addr)
                UPS_OFF_CFG: begin
                    nxt_s.timeout = hwdata[UPS_CFG_TMO_LSB +: 16];
                    if (!cfg_bad) begin
                        nxt_s.mode   = new_mode;
                        nxt_s.state  = ST_ACTIVE;
                        nxt_s.frames = 16'h0;
                    end
                end
                UPS_OFF_CTRL: begin
                    nxt_s.fc_en   = hwdata[UPS_CTRL_FC_BIT];
                    nxt_s.variant = hwdata[UPS_CTRL_VAR_LSB +: 3];
                end
                UPS_OFF_STAT: begin
                    if (hwdata[UPS_STAT_REJ_BIT]) begin
                        nxt_s.reject = 1'b0;
                    end
                end
                default: nxt_s.reject = s_ff.reject;
            endcase
            // Set after clear so a refusal is never lost
            if (s_ff.wr_addr == UPS_OFF_CFG && cfg_bad) begin
                nxt_s.reject = 1'b1;
            end
        end

        // Outputs from the chosen next state
        nxt_s.port_en = (nxt_s.state == ST_ACTIVE) || (nxt_s.state == ST_WAKE) ||
                        (nxt_s.state == ST_WIN);
        nxt_s.active  = (nxt_s.state == ST_ACTIVE) || (nxt_s.state == ST_WIN);
        nxt_s.rx_accept = nxt_s.port_en && (nxt_s.state != ST_WAKE) &&
                          !(nxt_s.mode == UPS_MODE_RTS && !rts_is_on) &&
                          !(nxt_s.mode == UPS_MODE_DTR && !dtr_is_on);
        // CTS only meaningful with flow control; otherwise held ON
        nxt_s.cts_n = nxt_s.fc_en ? !nxt_s.port_en : 1'b0;
        nxt_s.dtr_on = dtr_is_on;
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_ff           <= '0;
            s_ff.rxd_sync  <= 3'h7;
            s_ff.rts_sync  <= 2'h3;
            s_ff.dtr_sync  <= 2'h3;
            s_ff.mode      <= UPS_RST_MODE;
            s_ff.timeout   <= UPS_RST_TMO;
            s_ff.state     <= ST_ACTIVE;
            s_ff.hreadyout <= 1'b1;
            s_ff.cts_n     <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hrdata      = s_ff.hrdata;
    assign hreadyout   = s_ff.hreadyout;
    assign hresp       = s_ff.cts_n & 1'b0;
    assign port_en     = s_ff.port_en;
    assign cts_n       = s_ff.cts_n;
    assign active_mode = s_ff.active;
    assign rx_accept   = s_ff.rx_accept;
    assign dtr_on      = s_ff.dtr_on;

    // Checks
    a_cts_tracks_en: assert property (@(posedge clk) disable iff (rst)
        s_ff.fc_en |-> (s_ff.cts_n == !s_ff.port_en))
        else $error("CTS does not follow port enable");
    a_mode0_always_on: assert property (@(posedge clk) disable iff (rst)
        (s_ff.mode == UPS_MODE_OFF) && $past(s_ff.mode == UPS_MODE_OFF) && !$past(rst) |->
        s_ff.port_en && s_ff.active && !(s_ff.cts_n && !s_ff.fc_en))
        else $error("Mode 0 left port off or idle");
    a_deep_port_off: assert property (@(posedge clk) disable iff (rst)
        (s_ff.state == ST_DEEP) |-> !s_ff.port_en && !s_ff.rx_accept)
        else $error("Port on in deep sleep");
    a_rts_off_close: assert property (@(posedge clk) disable iff (rst)
        (s_ff.mode == UPS_MODE_RTS) && !rts_is_on && !tx_pending && !psd_call &&
        !s_ff.wr_pend ##1 !rts_is_on && !tx_pending && !psd_call && !s_ff.wr_pend |-> !s_ff.port_en)
        else $error("RTS off did not close port");
    a_rts_on_keep: assert property (@(posedge clk) disable iff (rst)
        (s_ff.mode == UPS_MODE_RTS) && rts_is_on && s_ff.port_en && !s_ff.wr_pend |=>
        s_ff.port_en && (s_ff.state != ST_IDLE) && (s_ff.state != ST_DEEP))
        else $error("Port closed while RTS on");
    a_dtr_on_keep: assert property (@(posedge clk) disable iff (rst)
        (s_ff.mode == UPS_MODE_DTR) && dtr_is_on && s_ff.port_en && !s_ff.wr_pend |=>
        s_ff.port_en && (s_ff.state != ST_IDLE))
        else $error("Port closed while DTR on");
    a_dtr_off_close: assert property (@(posedge clk) disable iff (rst)
        (s_ff.mode == UPS_MODE_DTR) && (s_ff.state == ST_ACTIVE) && !dtr_is_on &&
        !tx_pending && !s_ff.wr_pend |=> (s_ff.state == ST_IDLE))
        else $error("DTR off did not close port");
    a_wake_discard: assert property (@(posedge clk) disable iff (rst)
        $rose(s_ff.state == ST_WAKE) |-> (s_ff.port_en && !s_ff.rx_accept && !s_ff.active)[*4])
        else $error("Data accepted during wake time");
    a_idle_wake_edge: assert property (@(posedge clk) disable iff (rst)
        cyc_mode && (s_ff.state == ST_IDLE) && !deep_req && rx_fall && !s_ff.wr_pend |=>
        (s_ff.state == ST_WAKE) && s_ff.port_en)
        else $error("Receive edge did not wake port");
    a_char_restart: assert property (@(posedge clk) disable iff (rst)
        cyc_mode && (s_ff.state == ST_ACTIVE) && rx_char |=> (s_ff.frames == 16'h0) && s_ff.active)
        else $error("Character did not restart timer");
    a_timeout_idle: assert property (@(posedge clk) disable iff (rst)
        cyc_mode && (s_ff.state == ST_ACTIVE) && (s_ff.frames >= s_ff.timeout) && !traffic &&
        !hold && !s_ff.wr_pend |=> !s_ff.port_en)
        else $error("Timeout did not close port");
    a_rts_cfg_guard: assert property (@(posedge clk) disable iff (rst)
        s_ff.wr_pend && (s_ff.wr_addr == UPS_OFF_CFG) && (new_mode == UPS_MODE_RTS) && s_ff.fc_en
        |=> $stable(s_ff.mode) && s_ff.reject)
        else $error("RTS mode taken with flow control");
    a_dtr_cfg_guard: assert property (@(posedge clk) disable iff (rst)
        s_ff.wr_pend && (s_ff.wr_addr == UPS_OFF_CFG) && (new_mode == UPS_MODE_DTR) &&
        (s_ff.variant > UPS_VAR_MAXONE) |=> $stable(s_ff.mode) && s_ff.reject)
        else $error("DTR mode taken with wrong variant");
endmodule : ups_ctrl

// *** sim/ups_host.sv ***
/*
 DTE model: drives RTS, DTR and the receive pin of the port.
 Assumes the bench asks for line levels and wake characters on clk.
*/
module ups_host #(
    parameter int P_GAP = 20  // Quiet time after a wake character
) (
    input  wire logic clk,       // Module clock
    input  wire logic rts_req,   // RTS ON wanted
    input  wire logic dtr_req,   // DTR ON wanted
    input  wire logic wake_req,  // Send one wake character
    output logic      rxd,       // Receive pin, idle high
    output logic      rts_n,     // RTS pin, low is ON
    output logic      dtr_n      // DTR pin, low is ON
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_cnt = 0;
    int gap_cnt = 0;
    // Handshake lines follow the requested levels
    assign rts_n = !rts_req;
    assign dtr_n = !dtr_req;
    // Low bits of the character, then the line idles high as if pulled up
    assign rxd = (bit_cnt == 0);
    // Held back after a wake character, so no data lands in the wake time
    always @(posedge clk) begin
        if (wake_req && gap_cnt == 0) begin
            bit_cnt <= 9;
            gap_cnt <= 9 + P_GAP;
        end else begin
            bit_cnt <= (bit_cnt > 0) ? bit_cnt - 1 : 0;
            gap_cnt <= (gap_cnt > 0) ? gap_cnt - 1 : 0;
        end
    end
endmodule : ups_host

// *** sim/test_uart_power_save_control.sv ***
/*
 Self-checking bench for the serial-port power-save controller.
 Assumes ups_ctrl with shortened counts and the DTE model ups_host.
*/
module test_uart_power_save_control;
    timeunit 1ns;
    timeprecision 1ns;
    import ups_pkg::*;
    localparam int W = 20;
    localparam int WN = 30;
    localparam int OF = 100;
    logic        clk, rst, hsel, hwrite, hresp, hreadyout, rx_char, tx_char, tx_pending, psd_call;
    logic        net_wake, net_reg, deep_req, rts_req, dtr_req, wake_req, rxd, rts_n, dtr_n;
    logic        port_en, cts_n, active_mode, rx_accept, dtr_on;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          err_total, checks_done;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [31:0] cfg;
        logic [5:0]  ins;  // rts, dtr, tx_pending, psd_call, net_wake, deep_req
        logic [3:0]  exp;  // port_en, cts_n, rx_accept, active_mode
        logic [3:0]  msk;
    } ups_row_t;
    ups_row_t rows [11];

    ups_ctrl #(.P_WAKE_CYC(W), .P_WIN_CYC(WN), .P_OFF_CYC(OF), .P_FRAME_CYC(8)) DUT (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rxd(rxd), .rts_n(rts_n), .dtr_n(dtr_n), .rx_char(rx_char), .tx_char(tx_char),
        .tx_pending(tx_pending), .psd_call(psd_call), .net_wake(net_wake), .net_reg(net_reg),
        .deep_req(deep_req), .port_en(port_en), .cts_n(cts_n), .active_mode(active_mode),
        .rx_accept(rx_accept), .dtr_on(dtr_on));
    ups_host #(.P_GAP(W)) host (.clk(clk), .rts_req(rts_req), .dtr_req(dtr_req), .wake_req(wake_req),
        .rxd(rxd), .rts_n(rts_n), .dtr_n(dtr_n));

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude;
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Ready is looked at just before the edge, so the edge's own update cannot race
    task automatic phase;
        int n;
        logic rdy;
        n = 0;
        do begin
            @(negedge clk);
            rdy = hreadyout;
            rd = hrdata;
            n++;
            @(posedge clk);
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            err_total++;
            conclude();
        end
    endtask : phase

    // One single word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        phase();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        phase();
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    task automatic obs(input logic [3:0] e, input logic [3:0] m);
        @(negedge clk);
        chk("port_en cts_n rx_accept active_mode", {28'h0, {port_en, cts_n, rx_accept, active_mode} & m},
            {28'h0, e & m});
        @(posedge clk);
    endtask : obs

    // Bounded wait for the port enable; running out ends the run
    task automatic wport(input logic v, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(negedge clk);
            if (port_en === v) break;
        end
        chk("port_en", {31'h0, port_en}, {31'h0, v});
        if (port_en !== v) conclude();
        @(posedge clk);
    endtask : wport

    task automatic wake;
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
    endtask : wake

    initial begin
        rows = '{
            '{8'h01, 32'h0002_0000, 6'h00, 4'hb, 4'hf},
            '{8'h01, 32'h0002_0001, 6'h00, 4'h4, 4'hd},
            '{8'h01, 32'h0002_0001, 6'h08, 4'h9, 4'hd},
            '{8'h01, 32'h0002_0004, 6'h04, 4'h9, 4'hd},
            '{8'h00, 32'h0002_0004, 6'h02, 4'h9, 4'hd},
            '{8'h00, 32'h0002_0002, 6'h20, 4'hb, 4'hf},
            '{8'h00, 32'h0002_0002, 6'h00, 4'h0, 4'he},
            '{8'h00, 32'h0002_0002, 6'h04, 4'h8, 4'ha},
            '{8'h01, 32'h0002_0003, 6'h10, 4'hb, 4'hf},
            '{8'h01, 32'h0002_0003, 6'h00, 4'h4, 4'he},
            '{8'h11, 32'h0002_0003, 6'h04, 4'h4, 4'hc}};
        {hsel, hwrite, rx_char, tx_char, tx_pending, psd_call, net_wake, deep_req} = '0;
        {rts_req, dtr_req, wake_req, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        net_reg = 1'b1;
        rst = 1'b1;
        err_total = 0;
        checks_done = 0;
        cyc(4);
        rst <= 1'b0;
        @(posedge clk);
        // Register defaults and an unmapped word
        ahb(1'b0, UPS_OFF_CFG, 32'h0);
        chk("cfg", rd, 32'h07d0_0000);
        ahb(1'b0, UPS_OFF_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        ahb(1'b0, UPS_OFF_STAT, 32'h0);
        chk("stat", rd, 32'h13);
        wr(8'h0c, 32'hffff_ffff);
        ahb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        foreach (rows[i]) begin
            wr(UPS_OFF_CTRL, {24'h0, rows[i].ctrl});
            wr(UPS_OFF_CFG, rows[i].cfg);
            {rts_req, dtr_req, tx_pending, psd_call, net_wake, deep_req} <= rows[i].ins;
            cyc(40);
            obs(rows[i].exp, rows[i].msk);
        end
        psd_call <= 1'b0;
        // Refused modes keep the old one and set the sticky flag
        wr(UPS_OFF_CTRL, 32'h01);
        wr(UPS_OFF_CFG, 32'h0002_0001);
        wr(UPS_OFF_CFG, 32'h0002_0002);
        ahb(1'b0, UPS_OFF_CFG, 32'h0);
        chk("cfg", rd, 32'h0002_0001);
        wr(UPS_OFF_STAT, 32'h8);
        wr(UPS_OFF_CTRL, 32'h20);
        wr(UPS_OFF_CFG, 32'h0002_0003);
        ahb(1'b0, UPS_OFF_STAT, 32'h0);
        chk("reject", {31'h0, rd[3]}, 32'h1);
        ahb(1'b0, UPS_OFF_CFG, 32'h0);
        chk("cfg", rd, 32'h0002_0001);
        wr(UPS_OFF_STAT, 32'h8);
        // Wake character, then traffic keeps the port open
        wport(1'b0, 60);
        wake();
        wport(1'b1, 20);
        obs(4'h8, 4'ha);
        cyc(W);
        obs(4'hb, 4'hb);
        repeat (8) begin
            rx_char <= 1'b1;
            @(posedge clk);
            rx_char <= 1'b0;
            cyc(9);
        end
        // Sent character keeps the port open too
        tx_char <= 1'b1;
        @(posedge clk);
        tx_char <= 1'b0;
        cyc(9);
        obs(4'h8, 4'h8);
        wport(1'b0, 40);
        // Deep sleep ignores the receive line
        deep_req <= 1'b1;
        cyc(5);
        ahb(1'b0, UPS_OFF_STAT, 32'h0);
        chk("deep", {31'h0, rd[2]}, 32'h1);
        wake();
        cyc(30);
        obs(4'h0, 4'h9);
        deep_req <= 1'b0;
        // RTS mode: line wake refused, RTS edge wakes
        wr(UPS_OFF_CTRL, 32'h0);
        wr(UPS_OFF_CFG, 32'h0002_0002);
        wport(1'b0, 20);
        wake();
        cyc(25);
        obs(4'h0, 4'h8);
        rts_req <= 1'b1;
        wport(1'b1, 10);
        cyc(W + 4);
        obs(4'hb, 4'hb);
        rts_req <= 1'b0;
        // DTR mode with flow control
        wr(UPS_OFF_CTRL, 32'h01);
        wr(UPS_OFF_CFG, 32'h0002_0003);
        wport(1'b0, 20);
        chk("dtr_on", {31'h0, dtr_on}, 32'h0);
        dtr_req <= 1'b1;
        wport(1'b1, 10);
        cyc(W + 4);
        obs(4'hb, 4'hf);
        chk("dtr_on", {31'h0, dtr_on}, 32'h1);
        dtr_req <= 1'b0;
        // Unregistered: long closed time, then open window
        net_reg <= 1'b0;
        wr(UPS_OFF_CFG, 32'h0064_0001);
        wport(1'b0, 900);
        cyc(OF - 10);
        obs(4'h0, 4'h8);
        wport(1'b1, 20);
        cyc(WN - 10);
        obs(4'h8, 4'h8);
        wport(1'b0, 20);
        // Second reset in mid-run
        rst <= 1'b1;
        cyc(2);
        obs(4'h4, 4'hf);
        rst <= 1'b0;
        cyc(2);
        obs(4'hb, 4'hf);
        conclude();
    end
endmodule : test_uart_power_save_control
